//--- rtl/dpot_top.sv
// Serial slave front end and register logic of a 256-tap potentiometer.
// Assumes all serial pins are asynchronous to clk and sck is far slower.
// Behaviour
// - Serial output changes on sck falling edge
// - Serial input sampled on sck rising edge
// - Hold freezes the sequence in progress
// - Execute only when strap address matches
// - Chip select high: output high impedance
// - Deselected: standby unless write still running
// - Ignore everything until a chip select fall
// - Write protect low blocks preset writes
// - Wiper value decodes to one tap
// - Never more than one tap enabled
// - Direct write loads wiper serially
// - Transfer loads wiper from chosen preset
// - Increment/decrement steps wiper by one
// - Reset recalls preset zero into wiper
// - Wiper is volatile, reloaded from a preset at reset or by transfer
// - Four 8-bit presets, host readable and writable
// - Data moves both ways wiper and presets
// - Preset write completes within 10 ms
// - Busy bit high during nonvolatile write
// - First byte carries type and address
// - Step up on high input, down on low
// - Commit preset write on chip select rise
// - Read-status returns the busy bit
`include "dpot_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module dpot_top #(
  parameter int NV_WRITE_CYC = `DPOT_NV_WRITE_CYC
) (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Serial bus pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so_o,
  output logic so_oe,
  // Address straps
  input wire logic addr_strap_hi,
  input wire logic addr_strap_lo,
  // Potentiometer side
  output logic [255:0] tap_en,
  output dpot_pkg::dpot_byte_t wiper_position_reg,
  output logic nv_write_busy,
  output logic standby
);
  import dpot_pkg::*;

  localparam int CW = $clog2(NV_WRITE_CYC + 1);

  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic hold_n_s;
  logic wp_n_s;
  logic a_hi_s;
  logic a_lo_s;

  // Reset values are the idle pin levels, so no false edge follows reset
  dpot_sync #(.W(7), .RST_VAL(7'h4c)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d({cs_n, sck, si, hold_n, wp_n, addr_strap_hi, addr_strap_lo}),
    .q({cs_n_s, sck_s, si_s, hold_n_s, wp_n_s, a_hi_s, a_lo_s})
  );

  dpot_state_e state_r, state_nxt;
  logic cs_d_r, cs_d_nxt;
  logic sck_d_r, sck_d_nxt;
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  dpot_byte_t sh_r, sh_nxt;
  logic [3:0] op_r, op_nxt;
  logic [1:0] idx_r, idx_nxt;
  dpot_byte_t tx_r, tx_nxt;
  logic so_r, so_nxt;
  dpot_byte_t wiper_r, wiper_nxt;
  dpot_byte_t preset_reg [4];
  dpot_byte_t preset_nxt [4];
  logic pend_r, pend_nxt;
  logic [1:0] pend_idx_r, pend_idx_nxt;
  dpot_byte_t pend_dat_r, pend_dat_nxt;
  logic [CW-1:0] busy_cnt_r, busy_cnt_nxt;

  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic busy;
  logic byte_done;
  dpot_byte_t byte_in;

  // Edges are found on the synchronised copies, never the raw pins
  assign cs_fall = cs_d_r && !cs_n_s;
  assign cs_rise = !cs_d_r && cs_n_s;
  assign sck_rise = !sck_d_r && sck_s;
  assign sck_fall = sck_d_r && !sck_s;
  assign busy = (busy_cnt_r != '0);
  assign byte_done = (bit_cnt_r == 3'h7);
  assign byte_in = {sh_r[6:0], si_s};

  always_comb
  begin
    state_nxt = state_r;
    cs_d_nxt = cs_n_s;
    sck_d_nxt = sck_s;
    bit_cnt_nxt = bit_cnt_r;
    sh_nxt = sh_r;
    op_nxt = op_r;
    idx_nxt = idx_r;
    tx_nxt = tx_r;
    so_nxt = so_r;
    wiper_nxt = wiper_r;
    preset_nxt = preset_reg;
    pend_nxt = pend_r;
    pend_idx_nxt = pend_idx_r;
    pend_dat_nxt = pend_dat_r;
    busy_cnt_nxt = busy_cnt_r;

    // Nonvolatile cell update lands at the end of the write time
    if (busy)
    begin
      busy_cnt_nxt = busy_cnt_r - CW'(1);
      if (busy_cnt_r == CW'(1))
        preset_nxt[pend_idx_r] = pend_dat_r;
    end
    else if (cs_rise && pend_r)
    begin
      busy_cnt_nxt = CW'(NV_WRITE_CYC);
      pend_nxt = 1'b0;
    end

    if (state_r == ST_RECALL)
    begin
      wiper_nxt = preset_reg[0];
      state_nxt = ST_IDLE;
    end
    else if (cs_n_s)
      state_nxt = ST_IDLE;
    else if (cs_fall)
    begin
      // Only a falling select opens a frame; a select held low at reset
      // release still shows as a fall once the synchroniser leaves its reset level
      state_nxt = ST_ID;
      bit_cnt_nxt = 3'h0;
      pend_nxt = 1'b0;
    end
    else if (hold_n_s && state_r != ST_IDLE)
    begin
      if (sck_rise)
      begin
        sh_nxt = byte_in;
        bit_cnt_nxt = bit_cnt_r + 3'h1;
        case (state_r)
          ST_ID:
            if (byte_done)
            begin
              if (byte_in[`DPOT_ID_TYPE_HI:`DPOT_ID_TYPE_LO] ==
                  `DPOT_ID_TYPE &&
                  byte_in[`DPOT_ID_ADDR_HI] == a_hi_s &&
                  byte_in[`DPOT_ID_ADDR_LO] == a_lo_s)
                state_nxt = ST_INSTR;
              else
                state_nxt = ST_SKIP;
            end
          ST_INSTR:
            if (byte_done)
            begin
              op_nxt = byte_in[`DPOT_OP_HI:`DPOT_OP_LO];
              idx_nxt = byte_in[`DPOT_IDX_HI:`DPOT_IDX_LO];
              state_nxt = ST_SKIP;
              case (byte_in[`DPOT_OP_HI:`DPOT_OP_LO])
                `DPOT_OP_RD_WIPER:
                begin
                  tx_nxt = wiper_r;
                  state_nxt = ST_DATA_OUT;
                end
                `DPOT_OP_RD_PRESET:
                begin
                  tx_nxt = preset_reg[byte_in[`DPOT_IDX_HI:`DPOT_IDX_LO]];
                  state_nxt = ST_DATA_OUT;
                end
                `DPOT_OP_RD_STATUS:
                begin
                  tx_nxt = {7'h00, busy};
                  state_nxt = ST_DATA_OUT;
                end
                `DPOT_OP_WR_WIPER,
                `DPOT_OP_WR_PRESET:
                  state_nxt = ST_DATA_IN;
                `DPOT_OP_XFR_TO_WIPER:
                  wiper_nxt =
                    preset_reg[byte_in[`DPOT_IDX_HI:`DPOT_IDX_LO]];
                `DPOT_OP_XFR_TO_PRESET:
                  if (wp_n_s && !busy)
                  begin
                    pend_nxt = 1'b1;
                    pend_idx_nxt = byte_in[`DPOT_IDX_HI:`DPOT_IDX_LO];
                    pend_dat_nxt = wiper_r;
                  end
                `DPOT_OP_INCDEC:
                  state_nxt = ST_INCDEC;
                default:
                  state_nxt = ST_SKIP;
              endcase
            end
          ST_DATA_IN:
            if (byte_done)
            begin
              state_nxt = ST_SKIP;
              if (op_r == `DPOT_OP_WR_WIPER)
                wiper_nxt = byte_in;
              else if (wp_n_s && !busy)
              begin
                // Write protect or a running write drops the request
                pend_nxt = 1'b1;
                pend_idx_nxt = idx_r;
                pend_dat_nxt = byte_in;
              end
            end
          ST_DATA_OUT:
            if (byte_done)
              state_nxt = ST_SKIP;
          ST_INCDEC:
            if (si_s && wiper_r != 8'hff)
              wiper_nxt = wiper_r + 8'h01;
            else if (!si_s && wiper_r != 8'h00)
              wiper_nxt = wiper_r - 8'h01;
          default:
            ;
        endcase
      end
      else if (sck_fall && state_r == ST_DATA_OUT)
      begin
        so_nxt = tx_r[7];
        tx_nxt = {tx_r[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_r <= ST_RECALL;
      cs_d_r <= 1'b1;
      sck_d_r <= 1'b0;
      bit_cnt_r <= 3'h0;
      sh_r <= 8'h00;
      op_r <= 4'h0;
      idx_r <= 2'h0;
      tx_r <= 8'h00;
      so_r <= 1'b0;
      wiper_r <= `DPOT_WIPER_RST;
      pend_r <= 1'b0;
      pend_idx_r <= 2'h0;
      pend_dat_r <= 8'h00;
      busy_cnt_r <= '0;
      for (int k = 0; k < 4; k++)
        preset_reg[k] <= `DPOT_PRESET_INIT;
    end
    else
    begin
      state_r <= state_nxt;
      cs_d_r <= cs_d_nxt;
      sck_d_r <= sck_d_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      sh_r <= sh_nxt;
      op_r <= op_nxt;
      idx_r <= idx_nxt;
      tx_r <= tx_nxt;
      so_r <= so_nxt;
      wiper_r <= wiper_nxt;
      pend_r <= pend_nxt;
      pend_idx_r <= pend_idx_nxt;
      pend_dat_r <= pend_dat_nxt;
      busy_cnt_r <= busy_cnt_nxt;
      preset_reg <= preset_nxt;
    end
  end

  dpot_tap_decode #(.N(8)) u_decode (
    .clk(clk),
    .sys_rst(sys_rst),
    .pos(wiper_r),
    .tap_en(tap_en)
  );

  assign so_o = so_r;
  assign so_oe = !cs_n_s && state_r == ST_DATA_OUT;
  assign wiper_position_reg = wiper_r;
  assign nv_write_busy = busy;
  assign standby = cs_n_s && !busy;

  chk_so_hiz_desel: assert property (@(posedge clk) disable iff (sys_rst)
    cs_n_s |-> !so_oe) else $error("output driven while deselected");

  chk_tap_onehot: assert property (@(posedge clk) disable iff (sys_rst)
    $onehot(tap_en)) else $error("tap enables not one-hot");

  chk_tap_follows: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 tap_en[$past(wiper_r)]) else $error("tap does not match");

  chk_so_on_fall: assert property (@(posedge clk) disable iff (sys_rst)
    !sck_fall |=> $stable(so_r)) else $error("output moved off edge");

  chk_hold_freeze: assert property (@(posedge clk) disable iff (sys_rst)
    (!hold_n_s && !cs_n_s && !cs_fall && state_r != ST_RECALL) |=>
    $stable(bit_cnt_r) && $stable(state_r))
    else $error("sequence moved during hold");

  chk_wp_blocks: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(pend_r) |-> $past(wp_n_s)) else $error("protected write");

  chk_commit_cs: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(busy) |-> $past(cs_rise) && $past(pend_r))
    else $error("write began without select rise");

  chk_busy_len: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(busy) |-> busy_cnt_r == CW'(NV_WRITE_CYC))
    else $error("write time wrong");

  chk_incdec_sat: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_INCDEC && hold_n_s && !cs_n_s && !cs_fall &&
     sck_rise && si_s && wiper_r == 8'hff) |=> wiper_r == 8'hff)
    else $error("wiper wrapped");

  chk_addr_match: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_ID && state_nxt == ST_INSTR) |->
    byte_in[1:0] == {a_hi_s, a_lo_s}) else $error("address mismatch");

  chk_recall: assert property (@(posedge clk)
    $fell(sys_rst) |=> wiper_r == preset_reg[0])
    else $error("no recall after reset");
endmodule
`default_nettype wire

//--- rtl/dpot_consts.svh
// Constants of the serial digital potentiometer front end.
// Included by the top module; holds definitions only.
`ifndef DPOT_CONSTS_SVH
`define DPOT_CONSTS_SVH

// Identification byte: type field in [7:4], strap bits in [1:0]
`define DPOT_ID_TYPE 4'ha
`define DPOT_ID_TYPE_HI 7
`define DPOT_ID_TYPE_LO 4
`define DPOT_ID_ADDR_HI 1
`define DPOT_ID_ADDR_LO 0

// Instruction byte: opcode in [7:4], preset index in [3:2]
`define DPOT_OP_HI 7
`define DPOT_OP_LO 4
`define DPOT_IDX_HI 3
`define DPOT_IDX_LO 2

`define DPOT_OP_RD_WIPER 4'h9
`define DPOT_OP_WR_WIPER 4'ha
`define DPOT_OP_RD_PRESET 4'hb
`define DPOT_OP_WR_PRESET 4'hc
`define DPOT_OP_XFR_TO_WIPER 4'hd
`define DPOT_OP_XFR_TO_PRESET 4'he
`define DPOT_OP_INCDEC 4'h2
`define DPOT_OP_RD_STATUS 4'h5

// Reset contents of the preset store and wiper
`define DPOT_PRESET_INIT 8'h80
`define DPOT_WIPER_RST 8'h00

// Nonvolatile write time and the cycle count at the system clock
`define DPOT_NV_WRITE_MS 10
`define DPOT_CLK_KHZ 125000
`define DPOT_NV_WRITE_CYC (`DPOT_CLK_KHZ * `DPOT_NV_WRITE_MS)

`endif

//--- rtl/dpot_pkg.sv
// Types shared by the potentiometer front end.
// No surroundings assumed.
package dpot_pkg;
  typedef enum logic [2:0] {
    ST_RECALL,
    ST_IDLE,
    ST_ID,
    ST_INSTR,
    ST_DATA_IN,
    ST_DATA_OUT,
    ST_INCDEC,
    ST_SKIP
  } dpot_state_e;
  typedef logic [7:0] dpot_byte_t;
endpackage

//--- rtl/dpot_sync.sv
// Two-stage synchroniser, one per bit.
// Assumes asynchronous inputs and a single system clock.
`timescale 1ns/1ns
`default_nettype none
module dpot_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  genvar i;
  for (i = 0; i < W; i++)
  begin : g_bit
    logic meta_r;
    logic q_r;
    always_ff @(posedge clk)
    begin
      if (sys_rst)
      begin
        meta_r <= RST_VAL[i];
        q_r <= RST_VAL[i];
      end
      else
      begin
        meta_r <= d[i];
        q_r <= meta_r;
      end
    end
    assign q[i] = q_r;
  end
endmodule
`default_nettype wire

//--- rtl/dpot_tap_decode.sv
// Registered one-hot decode of the wiper position onto tap switches.
// Assumes the position comes from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module dpot_tap_decode #(
  parameter int N = 8
) (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Position in, switch enables out
  input wire logic [N-1:0] pos,
  output logic [2**N-1:0] tap_en
);
  genvar i;
  for (i = 0; i < 2**N; i++)
  begin : g_tap
    localparam logic [N-1:0] IDX = N'(i);
    logic en_r;
    logic en_nxt;
    always_comb
    begin
      en_nxt = (pos == IDX);
    end
    always_ff @(posedge clk)
    begin
      if (sys_rst)
        en_r <= (i == 0);
      else
        en_r <= en_nxt;
    end
    assign tap_en[i] = en_r;
  end
endmodule
`default_nettype wire

//--- verif/dpot_master.sv
// Bus master model for the potentiometer's serial port, mode 0, MSB first.
// Assumes a resolved serial output line; sck period is 8 clk (64 ns).
`timescale 1ns/1ns
`default_nettype none
module dpot_master (
  // System
  input wire logic clk,
  // Serial pins
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  input wire logic so_line
);
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Read data is taken at the rise, before the device can drop its enable
  task automatic bit_x(input logic b, output logic r);
    si <= b;
    wait_clk(4);
    r = so_line;
    sck <= 1'b1;
    wait_clk(4);
    sck <= 1'b0;
  endtask

  // Pulses inside the pause carry junk that must not be taken
  task automatic pause();
    logic r;
    wait_clk(2);
    hold_n <= 1'b0;
    repeat (2) bit_x(1'b1, r);
    wait_clk(4);
    hold_n <= 1'b1;
    wait_clk(4);
  endtask

  task automatic byte_x(input logic [7:0] tx, input int hp,
    output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      if (i == hp)
        pause();
      bit_x(tx[i], rx[i]);
    end
  endtask

  // Sends id and instruction, then nb bits of dat (0, steps, or a byte)
  task automatic frame(input logic [7:0] id, input logic [7:0] ins,
    input logic [7:0] dat, input int nb, input int hp,
    output logic [7:0] rx);
    logic [7:0] junk;
    rx = 8'h00;
    cs_n <= 1'b0;
    wait_clk(4);
    byte_x(id, 8, junk);
    byte_x(ins, hp, junk);
    for (int i = 7; i > 7 - nb; i--)
      bit_x(dat[i], rx[i]);
    wait_clk(4);
    cs_n <= 1'b1;
    // Input moves while deselected and must be ignored
    si <= ~si;
    wait_clk(8);
  endtask
endmodule
`default_nettype wire

//--- verif/dpot_top_test.sv
// Self-checking bench for the potentiometer front end.
// Assumes the master model and a shortened nonvolatile write time.
`include "dpot_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module dpot_top_test;
  import dpot_pkg::*;
  localparam int NV = 400;
  localparam logic [1:0] ME = 2'b10;
  typedef struct {
    logic [3:0] op;
    logic [7:0] dat;
    int nb;
    logic [7:0] want;
  } dpot_row_s;
  dpot_row_s rows [7] = '{
    '{`DPOT_OP_WR_WIPER, 8'hff, 8, 8'hff},
    '{`DPOT_OP_INCDEC, 8'hc0, 2, 8'hff},
    '{`DPOT_OP_WR_WIPER, 8'h00, 8, 8'h00},
    '{`DPOT_OP_INCDEC, 8'h00, 1, 8'h00},
    '{`DPOT_OP_WR_WIPER, 8'h7f, 8, 8'h7f},
    '{`DPOT_OP_INCDEC, 8'ha0, 3, 8'h80},
    '{`DPOT_OP_WR_WIPER, 8'h5a, 8, 8'h5a}};
  logic clk;
  logic sys_rst;
  logic wp_n;
  logic addr_hi;
  logic addr_lo;
  wire cs_n;
  wire sck;
  wire si;
  wire hold_n;
  logic so_o;
  logic so_oe;
  logic [255:0] tap_en;
  dpot_byte_t wiper;
  logic busy;
  logic standby;
  logic [7:0] rx;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  wire so_line = so_oe ? so_o : 1'bz;

  dpot_master i_dpot_master (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .so_line(so_line));

  dpot_top #(.NV_WRITE_CYC(NV)) i_dpot_top (.clk(clk), .sys_rst(sys_rst),
    .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n),
    .so_o(so_o), .so_oe(so_oe), .addr_strap_hi(addr_hi),
    .addr_strap_lo(addr_lo), .tap_en(tap_en), .wiper_position_reg(wiper),
    .nv_write_busy(busy), .standby(standby));

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [255:0] seen,
    input logic [255:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cmd(input logic [1:0] a, input logic [3:0] op,
    input logic [1:0] idx, input logic [7:0] dat, input int nb,
    input int hp);
    i_dpot_master.frame({`DPOT_ID_TYPE, 2'b00, a}, {op, idx, 2'b00},
      dat, nb, hp, rx);
  endtask

  // Bounded wait for the end of a nonvolatile write
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < NV + 40)
    begin
      @(posedge clk);
      n++;
    end
    check("busy end", busy, 1'b0);
    check("standby", standby, 1'b1);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      test_done();
    end
  end

  initial
  begin
    sys_rst = 1'b1;
    wp_n = 1'b1;
    addr_hi = ME[1];
    addr_lo = ME[0];
    // Synchronisers reset to idle pin levels, so two edges suffice
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    check("recall", wiper, `DPOT_PRESET_INIT);
    check("taps", tap_en, 256'h1 << 8'h80);
    check("so idle", so_oe, 1'b0);
    check("standby", standby, 1'b1);
    check("busy", busy, 1'b0);
    foreach (rows[k])
    begin
      cmd(ME, rows[k].op, 2'd0, rows[k].dat, rows[k].nb, 8);
      check("wiper", wiper, rows[k].want);
      check("taps", tap_en, 256'h1 << rows[k].want);
      cmd(ME, `DPOT_OP_RD_WIPER, 2'd0, 8'h00, 8, 8);
      check("wiper read", rx, rows[k].want);
      check("so idle", so_oe, 1'b0);
    end
    // Pause in mid instruction byte
    cmd(ME, `DPOT_OP_WR_WIPER, 2'd0, 8'h3c, 8, 4);
    check("held write", wiper, 8'h3c);
    cmd(2'b01, `DPOT_OP_WR_WIPER, 2'd0, 8'h11, 8, 8);
    check("foreign addr", wiper, 8'h3c);
    wp_n <= 1'b0;
    cmd(ME, `DPOT_OP_WR_PRESET, 2'd1, 8'h77, 8, 8);
    check("protected", busy, 1'b0);
    wp_n <= 1'b1;
    cmd(ME, `DPOT_OP_RD_PRESET, 2'd1, 8'h00, 8, 8);
    check("preset 1", rx, `DPOT_PRESET_INIT);
    cmd(ME, `DPOT_OP_WR_PRESET, 2'd2, 8'hc3, 8, 8);
    check("busy", busy, 1'b1);
    check("standby", standby, 1'b0);
    cmd(ME, `DPOT_OP_RD_STATUS, 2'd0, 8'h00, 8, 8);
    check("status", rx, 8'h01);
    wait_idle();
    cmd(ME, `DPOT_OP_RD_STATUS, 2'd0, 8'h00, 8, 8);
    check("status", rx, 8'h00);
    cmd(ME, `DPOT_OP_RD_PRESET, 2'd2, 8'h00, 8, 8);
    check("preset 2", rx, 8'hc3);
    cmd(ME, `DPOT_OP_XFR_TO_WIPER, 2'd2, 8'h00, 0, 8);
    check("xfr in", wiper, 8'hc3);
    cmd(ME, `DPOT_OP_WR_WIPER, 2'd0, 8'h99, 8, 8);
    cmd(ME, `DPOT_OP_XFR_TO_PRESET, 2'd3, 8'h00, 0, 8);
    check("busy", busy, 1'b1);
    wait_idle();
    cmd(ME, `DPOT_OP_RD_PRESET, 2'd3, 8'h00, 8, 8);
    check("xfr out", rx, 8'h99);
    test_done();
  end
endmodule
`default_nettype wire
